//--- flash_guard_pkg.sv
// Constants for the flash clock divider, block protection and status logic
package flash_guard_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_UNLOCK_KEY  = 8'hF5;
	localparam logic [7:0] IDX_CLK_DIV     = 8'hF9;
	localparam logic [7:0] IDX_PROT_MASK   = 8'hFA;
	localparam logic [7:0] IDX_IRQ_STATUS  = 8'hFB;

	// ------------------------------------------------------------
	// Reset values and the locked-write protect value
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CLK_DIV     = 8'h01;
	localparam logic [7:0] RST_PROT_MASK   = 8'hFF;
	localparam logic [7:0] PROT_ALL        = 8'hFF;

	// ------------------------------------------------------------
	// Unlock key bytes
	// ------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST       = 8'hB6;
	localparam logic [7:0] KEY_SECOND      = 8'h49;

	// ------------------------------------------------------------
	// Status register field positions
	// ------------------------------------------------------------
	localparam int POS_DONE_IRQ_EN         = 7;
	localparam int POS_ERR_IRQ_EN          = 6;
	localparam int POS_DONE                = 5;
	localparam int POS_WR_VIOL             = 3;
	localparam int POS_ROW_TIMEOUT         = 2;
	localparam int POS_PG_VIOL             = 1;
	localparam int POS_MASS_VIOL           = 0;

	// ------------------------------------------------------------
	// Geometry and timing
	// ------------------------------------------------------------
	localparam int ADDR_W                  = 18;
	localparam int BLOCK_LSB               = 15;
	localparam logic [12:0] RP_TIMEOUT_TICKS = 13'h1300;

	// Unlock sequence states
	typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_type;

endpackage : flash_guard_pkg

//--- flash_guard.sv
// Flash timing divider, block write/erase guard and completion/error status
// ------------------------------------------------------------
// Function
// - System clock divided by divider value gives flash timing tick.
// - Divider is eight bits, values 01h to FFh, resets to 1.
// - Divider writes take effect only after the unlock key sequence.
// - Mask bit n guards 32 KB block n against writes and erases.
// - Reset leaves every block protected.
// - Boot block protected when write-protect pin asserted or bit 0 set.
// - Locked write to protection mask forces it to FFh.
// - Info page has no guard; mass erase includes it only when selected.
// - Two interrupt sources, completion and error, enabled by bits 7 and 6.
// - Row program exceeding 4864 ticks is aborted and sets time-out flag.
// - Write to protected block refused, write violation flag set.
// - Page erase of protected block refused, page erase flag set.
// - Mass erase with any block protected refused, mass flag set.
// - Error enable set means any error flag requests an interrupt.
// - Reading status clears completion and error flags, not enables.
// - Write-protect pin fails boot page erase and any mass erase.
// - Successful completion sets done flag and may request interrupt.
// ------------------------------------------------------------
//
// Our own choice: the Wishbone slave port.
module flash_guard
	import flash_guard_pkg::*;
(
	input  wire logic              MCLK,
	input  wire logic              RESETN,
	// Wishbone slave
	input  wire logic              CYC_I,
	input  wire logic              STB_I,
	input  wire logic              WE_I,
	input  wire logic [9:0]        ADR_I,
	input  wire logic [3:0]        SEL_I,
	input  wire logic [31:0]       DAT_I,
	output logic      [31:0]       DAT_O,
	output logic                   ACK_O,
	// Write-protect pin, active low, asynchronous
	input  wire logic              WP_N,
	// Information page select from the page register
	input  wire logic              INFO_PAGE_SEL,
	// Operation requests and completions from the flash sequencer
	input  wire logic [ADDR_W-1:0] OP_ADDR,
	input  wire logic              WRITE_REQ,
	input  wire logic              PAGE_ERASE_REQ,
	input  wire logic              MASS_ERASE_REQ,
	input  wire logic              ROW_PROGRAM_REQ,
	input  wire logic              ERASE_DONE,
	input  wire logic              ROW_DONE,
	// Results
	output logic                   WRITE_GRANT,
	output logic                   PAGE_ERASE_GRANT,
	output logic                   MASS_ERASE_GRANT,
	output logic                   MASS_INFO_INCLUDE,
	output logic                   ROW_PROGRAM_START,
	output logic                   ROW_ABORT,
	output logic                   FLASH_TICK,
	output logic                   IRQ
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0]          clk_div_ff;
	logic [7:0]          div_cnt_ff;
	logic [7:0]          prot_mask_ff;
	logic                completion_irq_enable_ff;
	logic                error_irq_enable_ff;
	logic                done_flag_ff;
	logic                write_violation_flag_ff;
	logic                row_program_timeout_flag_ff;
	logic                page_erase_violation_flag_ff;
	logic                full_erase_violation_flag_ff;
	key_state_type       key_state_ff;
	logic                wp_s1_ff;
	logic                wp_s2_ff;
	logic                wp_s3_ff;
	logic                wp_asserted_ff;
	logic [12:0]         rp_cnt_ff;
	logic                bus_req;
	logic                bus_wr;
	logic                bus_rd;
	logic [7:0]          reg_idx;
	logic [7:0]          wr_byte;
	logic                unlocked;
	logic                wr_div;
	logic                wr_prot;
	logic                rd_irq;
	logic                boot_block_guard;
	logic [7:0]          eff_mask;
	logic                addr_guarded;
	logic                mass_refuse;
	logic                page_refuse;
	logic                write_refuse;
	logic                row_refuse;
	logic                rp_expire;
	logic                row_finish;
	logic [7:0]          nxt_rdata;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// Requests are taken only while no answer is out, so each is seen once
	assign bus_req  = CYC_I && STB_I && !ACK_O;
	assign bus_wr   = bus_req && WE_I && SEL_I[0];
	assign bus_rd   = bus_req && !WE_I;
	assign reg_idx  = ADR_I[9:2];
	assign wr_byte  = DAT_I[7:0];
	assign unlocked = (key_state_ff == KEY_OPEN);
	assign wr_div   = bus_wr && (reg_idx == IDX_CLK_DIV);
	assign wr_prot  = bus_wr && (reg_idx == IDX_PROT_MASK);
	assign rd_irq   = bus_rd && (reg_idx == IDX_IRQ_STATUS);

	// Single-wait-state answer; unmapped indices ack with zero data
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			ACK_O <= 1'b0;
		end else begin
			ACK_O <= bus_req;
		end
	end

	// Read mux
	always_comb begin
		nxt_rdata = 8'h00;
		unique case (reg_idx)
			IDX_CLK_DIV:    nxt_rdata = clk_div_ff;
			IDX_PROT_MASK:  nxt_rdata = prot_mask_ff;
			IDX_IRQ_STATUS: nxt_rdata = {completion_irq_enable_ff, error_irq_enable_ff,
				done_flag_ff, 1'b0, write_violation_flag_ff,
				row_program_timeout_flag_ff, page_erase_violation_flag_ff,
				full_erase_violation_flag_ff};
			default:        nxt_rdata = 8'h00;
		endcase
	end

	// Read data captured with the answer, held otherwise
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			DAT_O <= 32'h0000_0000;
		end else if (bus_rd) begin
			DAT_O <= {24'h00_0000, nxt_rdata};
		end
	end

	// ------------------------------------------------------------
	// Unlock key sequence
	// ------------------------------------------------------------
	// Any other register write between the two key bytes breaks the sequence
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			key_state_ff <= KEY_IDLE;
		end else if (bus_wr && reg_idx == IDX_UNLOCK_KEY) begin
			if (wr_byte == KEY_FIRST) begin
				key_state_ff <= KEY_HALF;
			end else if (key_state_ff == KEY_HALF && wr_byte == KEY_SECOND) begin
				key_state_ff <= KEY_OPEN;
			end else begin
				key_state_ff <= KEY_IDLE;
			end
		end else if ((wr_div || wr_prot) && unlocked) begin
			key_state_ff <= KEY_IDLE;
		end else if (bus_wr && key_state_ff == KEY_HALF) begin
			key_state_ff <= KEY_IDLE;
		end
	end

	// ------------------------------------------------------------
	// Timing clock divider
	// ------------------------------------------------------------
	// Zero is not a legal divisor, so such a write leaves the value alone
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			clk_div_ff <= RST_CLK_DIV;
		end else if (wr_div && unlocked && wr_byte != 8'h00) begin
			clk_div_ff <= wr_byte;
		end
	end

	// Counter restarts on every unlocked divider write so the new period starts clean
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			div_cnt_ff <= 8'h00;
			FLASH_TICK <= 1'b0;
		end else if (wr_div && unlocked) begin
			div_cnt_ff <= 8'h00;
			FLASH_TICK <= 1'b0;
		end else if (div_cnt_ff >= clk_div_ff - 8'h01) begin
			div_cnt_ff <= 8'h00;
			FLASH_TICK <= 1'b1;
		end else begin
			div_cnt_ff <= div_cnt_ff + 8'h01;
			FLASH_TICK <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Block protection mask
	// ------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			prot_mask_ff <= RST_PROT_MASK;
		end else if (wr_prot && unlocked) begin
			prot_mask_ff <= wr_byte;
		end else if (wr_prot) begin
			prot_mask_ff <= PROT_ALL;
		end
	end

	// Pin synchroniser; level changes only once stages two and three agree
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			wp_s1_ff       <= 1'b1;
			wp_s2_ff       <= 1'b1;
			wp_s3_ff       <= 1'b1;
			wp_asserted_ff <= 1'b0;
		end else begin
			wp_s1_ff <= WP_N;
			wp_s2_ff <= wp_s1_ff;
			wp_s3_ff <= wp_s2_ff;
			if (wp_s2_ff == wp_s3_ff) begin
				wp_asserted_ff <= !wp_s3_ff;
			end
		end
	end

	// Effective mask and the guard for the addressed block
	assign boot_block_guard = prot_mask_ff[0] || wp_asserted_ff;
	assign eff_mask         = {prot_mask_ff[7:1], boot_block_guard};
	// Info page accesses carry no guard bit
	assign addr_guarded = !INFO_PAGE_SEL && eff_mask[OP_ADDR[ADDR_W-1:BLOCK_LSB]];

	// ------------------------------------------------------------
	// Operation screening
	// ------------------------------------------------------------
	// One request per cycle is expected; mass, page, row, write is the priority
	assign mass_refuse  = MASS_ERASE_REQ && ((|eff_mask) || wp_asserted_ff);
	assign page_refuse  = !MASS_ERASE_REQ && PAGE_ERASE_REQ && addr_guarded;
	assign row_refuse   = !MASS_ERASE_REQ && !PAGE_ERASE_REQ && ROW_PROGRAM_REQ
		&& !ROW_PROGRAM_START && addr_guarded;
	assign write_refuse = !MASS_ERASE_REQ && !PAGE_ERASE_REQ && !ROW_PROGRAM_REQ
		&& WRITE_REQ && addr_guarded;

	// Grants copy the screened request level one cycle later, refused work is simply never started
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			MASS_ERASE_GRANT  <= 1'b0;
			MASS_INFO_INCLUDE <= 1'b0;
			PAGE_ERASE_GRANT  <= 1'b0;
			WRITE_GRANT       <= 1'b0;
		end else begin
			MASS_ERASE_GRANT <= MASS_ERASE_REQ && !mass_refuse;
			if (MASS_ERASE_REQ && !mass_refuse) begin
				MASS_INFO_INCLUDE <= INFO_PAGE_SEL;
			end
			PAGE_ERASE_GRANT <= !MASS_ERASE_REQ && PAGE_ERASE_REQ && !page_refuse;
			WRITE_GRANT      <= !MASS_ERASE_REQ && !PAGE_ERASE_REQ && !ROW_PROGRAM_REQ
				&& WRITE_REQ && !write_refuse;
		end
	end

	// ------------------------------------------------------------
	// Row program and time-out
	// ------------------------------------------------------------
	assign rp_expire  = ROW_PROGRAM_START && FLASH_TICK && !ROW_DONE
		&& (rp_cnt_ff == RP_TIMEOUT_TICKS - 13'h0001);
	assign row_finish = ROW_PROGRAM_START && ROW_DONE;

	// Busy level doubles as the row-program control bit
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			ROW_PROGRAM_START <= 1'b0;
			ROW_ABORT         <= 1'b0;
			rp_cnt_ff         <= 13'h0000;
		end else begin
			ROW_ABORT <= rp_expire;
			if (rp_expire || row_finish) begin
				ROW_PROGRAM_START <= 1'b0;
				rp_cnt_ff         <= 13'h0000;
			end else if (ROW_PROGRAM_START) begin
				if (FLASH_TICK) begin
					rp_cnt_ff <= rp_cnt_ff + 13'h0001;
				end
			end else if (!MASS_ERASE_REQ && !PAGE_ERASE_REQ && ROW_PROGRAM_REQ && !row_refuse) begin
				ROW_PROGRAM_START <= 1'b1;
				rp_cnt_ff         <= 13'h0000;
			end
		end
	end

	// ------------------------------------------------------------
	// Status flags and enables
	// ------------------------------------------------------------
	// A new event in the clearing read's cycle survives: set beats clear
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			done_flag_ff                 <= 1'b0;
			write_violation_flag_ff      <= 1'b0;
			row_program_timeout_flag_ff  <= 1'b0;
			page_erase_violation_flag_ff <= 1'b0;
			full_erase_violation_flag_ff <= 1'b0;
		end else begin
			done_flag_ff <= (ERASE_DONE || row_finish)
				|| (done_flag_ff && !rd_irq);
			write_violation_flag_ff <= (write_refuse || row_refuse)
				|| (write_violation_flag_ff && !rd_irq);
			row_program_timeout_flag_ff <= rp_expire
				|| (row_program_timeout_flag_ff && !rd_irq);
			page_erase_violation_flag_ff <= page_refuse
				|| (page_erase_violation_flag_ff && !rd_irq);
			full_erase_violation_flag_ff <= mass_refuse
				|| (full_erase_violation_flag_ff && !rd_irq);
		end
	end

	// Enables are plain read/write and untouched by reads
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			completion_irq_enable_ff <= 1'b0;
			error_irq_enable_ff      <= 1'b0;
		end else if (bus_wr && reg_idx == IDX_IRQ_STATUS) begin
			completion_irq_enable_ff <= wr_byte[POS_DONE_IRQ_EN];
			error_irq_enable_ff      <= wr_byte[POS_ERR_IRQ_EN];
		end
	end

	// Request line follows the flags one cycle later
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= (completion_irq_enable_ff && done_flag_ff)
				|| (error_irq_enable_ff && (write_violation_flag_ff
				|| row_program_timeout_flag_ff || page_erase_violation_flag_ff
				|| full_erase_violation_flag_ff));
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_locked_prot_write;
		wr_prot && !unlocked;
	endsequence
	sequence s_open_write;
		(wr_div || wr_prot) && unlocked;
	endsequence

	a_locked_prot_force: assert property (@(posedge MCLK) disable iff (!RESETN)
		s_locked_prot_write |=> prot_mask_ff == PROT_ALL)
		else $error("Locked mask write did not protect all blocks");

	a_locked_div_hold: assert property (@(posedge MCLK) disable iff (!RESETN)
		(wr_div && !unlocked) |=> $stable(clk_div_ff))
		else $error("Locked divider write changed the divider");

	a_relock_after_write: assert property (@(posedge MCLK) disable iff (!RESETN)
		s_open_write |=> !unlocked ##1 1'b1)
		else $error("Unlock state survived a permitted write");

	// Window free of divider writes, since a write restarts the count
	a_tick_spacing: assert property (@(posedge MCLK) disable iff (!RESETN)
		(FLASH_TICK && clk_div_ff == 8'h03 && !wr_div) ##1 (!wr_div)[*2]
		|-> !$past(FLASH_TICK) && !FLASH_TICK ##1 FLASH_TICK)
		else $error("Timing tick spacing does not match divider");

	a_mass_refused: assert property (@(posedge MCLK) disable iff (!RESETN)
		(MASS_ERASE_REQ && |eff_mask) |=> !MASS_ERASE_GRANT && full_erase_violation_flag_ff)
		else $error("Mass erase ran with a protected block");

	a_page_refused: assert property (@(posedge MCLK) disable iff (!RESETN)
		(PAGE_ERASE_REQ && !MASS_ERASE_REQ && addr_guarded)
		|=> !PAGE_ERASE_GRANT && page_erase_violation_flag_ff)
		else $error("Page erase ran on a protected block");

	a_write_refused: assert property (@(posedge MCLK) disable iff (!RESETN)
		write_refuse |=> !WRITE_GRANT && write_violation_flag_ff)
		else $error("Write performed on a protected block");

	a_boot_guard_pin: assert property (@(posedge MCLK) disable iff (!RESETN)
		(WRITE_REQ && !MASS_ERASE_REQ && !PAGE_ERASE_REQ && !ROW_PROGRAM_REQ && !INFO_PAGE_SEL
		&& wp_asserted_ff && OP_ADDR[ADDR_W-1:BLOCK_LSB] == 3'h0) |=> !WRITE_GRANT)
		else $error("Boot block unguarded while pin asserted");

	a_row_timeout: assert property (@(posedge MCLK) disable iff (!RESETN)
		rp_expire |=> ROW_ABORT && !ROW_PROGRAM_START && row_program_timeout_flag_ff)
		else $error("Row program time-out not handled");

	a_read_clears_flags: assert property (@(posedge MCLK) disable iff (!RESETN)
		(rd_irq && !ERASE_DONE && !row_finish && !rp_expire && !MASS_ERASE_REQ
		&& !PAGE_ERASE_REQ && !ROW_PROGRAM_REQ && !WRITE_REQ)
		|=> !done_flag_ff && !write_violation_flag_ff && !row_program_timeout_flag_ff
		&& !page_erase_violation_flag_ff && !full_erase_violation_flag_ff
		&& $stable(error_irq_enable_ff))
		else $error("Status read did not clear flags");

	a_error_irq: assert property (@(posedge MCLK) disable iff (!RESETN)
		(error_irq_enable_ff && !bus_wr && (write_refuse || page_refuse || mass_refuse))
		##1 !bus_wr |=> IRQ)
		else $error("Error flag raised no interrupt");

	a_done_irq: assert property (@(posedge MCLK) disable iff (!RESETN)
		((ERASE_DONE || row_finish) && completion_irq_enable_ff && !bus_wr)
		|=> done_flag_ff ##1 IRQ)
		else $error("Completion raised no interrupt");

endmodule : flash_guard

//--- test_flash_clock_protect_irq.sv
// Self-checking bench for the flash divider, block guard and status logic
module test_flash_clock_protect_irq
	import flash_guard_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic              MCLK = 1'b0;
	logic              RESETN = 1'b0;
	logic              CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
	logic [9:0]        ADR_I = '0;
	logic [3:0]        SEL_I = 4'h1;
	logic [31:0]       DAT_I = '0;
	logic [31:0]       DAT_O;
	logic              ACK_O, WP_N = 1'b1, INFO_PAGE_SEL = 1'b0;
	logic [ADDR_W-1:0] OP_ADDR = '0;
	logic              WRITE_REQ = 1'b0, PAGE_ERASE_REQ = 1'b0, MASS_ERASE_REQ = 1'b0;
	logic              ROW_PROGRAM_REQ = 1'b0, ERASE_DONE = 1'b0, ROW_DONE = 1'b0;
	logic              WRITE_GRANT, PAGE_ERASE_GRANT, MASS_ERASE_GRANT, MASS_INFO_INCLUDE;
	logic              ROW_PROGRAM_START, ROW_ABORT, FLASH_TICK, IRQ;
	int                fails = 0;
	int                samples_checked = 0;
	logic              g;

	flash_guard flash_guard_i (.MCLK(MCLK), .RESETN(RESETN), .CYC_I(CYC_I), .STB_I(STB_I),
		.WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
		.WP_N(WP_N), .INFO_PAGE_SEL(INFO_PAGE_SEL), .OP_ADDR(OP_ADDR), .WRITE_REQ(WRITE_REQ),
		.PAGE_ERASE_REQ(PAGE_ERASE_REQ), .MASS_ERASE_REQ(MASS_ERASE_REQ),
		.ROW_PROGRAM_REQ(ROW_PROGRAM_REQ), .ERASE_DONE(ERASE_DONE), .ROW_DONE(ROW_DONE),
		.WRITE_GRANT(WRITE_GRANT), .PAGE_ERASE_GRANT(PAGE_ERASE_GRANT),
		.MASS_ERASE_GRANT(MASS_ERASE_GRANT), .MASS_INFO_INCLUDE(MASS_INFO_INCLUDE),
		.ROW_PROGRAM_START(ROW_PROGRAM_START), .ROW_ABORT(ROW_ABORT), .FLASH_TICK(FLASH_TICK),
		.IRQ(IRQ));

	// Free-running 125 MHz system clock
	always #4 MCLK = ~MCLK;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic tally_and_finish();
		if (fails == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish

	// Single classic cycle; data taken at the edge where ack is seen
	// No local limit on the wait: a missing ack is left to the watchdog
	task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
			output logic [7:0] rd);
		@(posedge MCLK);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I  <= we;
		ADR_I <= {idx, 2'b00};
		DAT_I <= {24'h00_0000, wd};
		do begin
			@(posedge MCLK);
		end while (ACK_O !== 1'b1);
		rd = DAT_O[7:0];
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
	endtask : wb_xfer

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		wb_xfer(1'b1, idx, d, r);
	endtask : wr

	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] want);
		logic [7:0] r;
		wb_xfer(1'b0, idx, 8'h00, r);
		check({24'h00_0000, r}, {24'h00_0000, want});
	endtask : rd_chk

	task automatic unlock();
		wr(IDX_UNLOCK_KEY, KEY_FIRST);
		wr(IDX_UNLOCK_KEY, KEY_SECOND);
	endtask : unlock

	// Kind 0 write, 1 page erase, 2 mass erase, 3 row program; returns the answer
	task automatic op(input int kind, input logic [ADDR_W-1:0] a, output logic gr);
		@(posedge MCLK);
		OP_ADDR <= a;
		case (kind)
			0: WRITE_REQ <= 1'b1;
			1: PAGE_ERASE_REQ <= 1'b1;
			2: MASS_ERASE_REQ <= 1'b1;
			default: ROW_PROGRAM_REQ <= 1'b1;
		endcase
		@(posedge MCLK);
		{WRITE_REQ, PAGE_ERASE_REQ, MASS_ERASE_REQ, ROW_PROGRAM_REQ} <= 4'h0;
		@(posedge MCLK);
		case (kind)
			0: gr = WRITE_GRANT;
			1: gr = PAGE_ERASE_GRANT;
			2: gr = MASS_ERASE_GRANT;
			default: gr = ROW_PROGRAM_START;
		endcase
	endtask : op

	// One-cycle completion pulse: erase done when row is 0, row done when 1
	task automatic pulse(input bit row);
		@(posedge MCLK);
		ERASE_DONE <= !row;
		ROW_DONE   <= row;
		@(posedge MCLK);
		{ERASE_DONE, ROW_DONE} <= 2'h0;
		repeat (2) @(posedge MCLK);
	endtask : pulse

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_values();
		rd_chk(IDX_CLK_DIV, 8'h01);
		rd_chk(IDX_PROT_MASK, 8'hFF);
		rd_chk(IDX_IRQ_STATUS, 8'h00);
		rd_chk(8'h10, 8'h00);
	endtask : t_reset_values

	task automatic t_divider();
		int n;
		wr(IDX_CLK_DIV, 8'h05);
		rd_chk(IDX_CLK_DIV, 8'h01);
		unlock();
		wr(IDX_CLK_DIV, 8'h03);
		rd_chk(IDX_CLK_DIV, 8'h03);
		wr(IDX_CLK_DIV, 8'h07);
		rd_chk(IDX_CLK_DIV, 8'h03);
		// Gap between two ticks must equal the divider value
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
		end while (FLASH_TICK !== 1'b1 && n < 600);
		n = 1;
		@(posedge MCLK);
		while (FLASH_TICK !== 1'b1 && n < 600) begin
			@(posedge MCLK);
			n++;
		end
		check(n, 3);
	endtask : t_divider

	task automatic t_protect();
		unlock();
		wr(IDX_PROT_MASK, 8'h01);
		rd_chk(IDX_PROT_MASK, 8'h01);
		// Top byte of each block; only block 0 is guarded
		for (int b = 0; b < 8; b++) begin
			op(0, {b[2:0], 15'h7FFF}, g);
			check(g, b != 0);
		end
		op(1, 18'h0_4000, g);
		check(g, 0);
		op(1, 18'h0_8000, g);
		check(g, 1);
		op(2, 18'h0_0000, g);
		check(g, 0);
		rd_chk(IDX_IRQ_STATUS, 8'h0B);
		rd_chk(IDX_IRQ_STATUS, 8'h00);
		wr(IDX_PROT_MASK, 8'h00);
		rd_chk(IDX_PROT_MASK, 8'hFF);
	endtask : t_protect

	task automatic t_write_pin();
		unlock();
		wr(IDX_PROT_MASK, 8'h00);
		WP_N <= 1'b0;
		repeat (6) @(posedge MCLK);
		op(1, 18'h0_0100, g);
		check(g, 0);
		op(2, 18'h0_0000, g);
		check(g, 0);
		op(0, 18'h0_0000, g);
		check(g, 0);
		op(0, 18'h0_8000, g);
		check(g, 1);
		rd_chk(IDX_IRQ_STATUS, 8'h0B);
		WP_N <= 1'b1;
		INFO_PAGE_SEL <= 1'b1;
		repeat (6) @(posedge MCLK);
		op(2, 18'h0_0000, g);
		check(g, 1);
		check(MASS_INFO_INCLUDE, 1);
		INFO_PAGE_SEL <= 1'b0;
		op(2, 18'h0_0000, g);
		check(MASS_INFO_INCLUDE, 0);
		pulse(1'b0);
		rd_chk(IDX_IRQ_STATUS, 8'h20);
	endtask : t_write_pin

	task automatic t_irq();
		wr(IDX_IRQ_STATUS, 8'hC0);
		rd_chk(IDX_IRQ_STATUS, 8'hC0);
		op(3, 18'h0_8000, g);
		check(g, 1);
		pulse(1'b1);
		check(ROW_PROGRAM_START, 0);
		check(IRQ, 1);
		rd_chk(IDX_IRQ_STATUS, 8'hE0);
		repeat (2) @(posedge MCLK);
		check(IRQ, 0);
		wr(IDX_PROT_MASK, 8'h00);
		op(0, 18'h1_0000, g);
		repeat (2) @(posedge MCLK);
		check(IRQ, 1);
		rd_chk(IDX_IRQ_STATUS, 8'hC8);
		INFO_PAGE_SEL <= 1'b1;
		op(0, 18'h0_0000, g);
		check(g, 1);
		INFO_PAGE_SEL <= 1'b0;
		wr(IDX_IRQ_STATUS, 8'h00);
		op(0, 18'h1_0000, g);
		repeat (3) @(posedge MCLK);
		check(IRQ, 0);
		rd_chk(IDX_IRQ_STATUS, 8'h08);
	endtask : t_irq

	task automatic t_timeout();
		int n;
		int c;
		unlock();
		wr(IDX_PROT_MASK, 8'h00);
		op(3, 18'h2_0000, g);
		// The tick standing as the request returns is already counted by the design
		n = (FLASH_TICK === 1'b1) ? 1 : 0;
		c = 0;
		// Count ticks seen while the row program stays open
		while (ROW_ABORT !== 1'b1 && c < 20000) begin
			@(posedge MCLK);
			c++;
			if (FLASH_TICK === 1'b1) n++;
		end
		check(ROW_ABORT, 1);
		check(ROW_PROGRAM_START, 0);
		check(n, 4864);
		rd_chk(IDX_IRQ_STATUS, 8'h04);
		unlock();
		wr(IDX_CLK_DIV, 8'h00);
		rd_chk(IDX_CLK_DIV, 8'h03);
	endtask : t_timeout

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge MCLK);
		RESETN <= 1'b1;
		t_reset_values();
		t_divider();
		t_protect();
		t_write_pin();
		t_irq();
		t_timeout();
		tally_and_finish();
	end

	// Cut a hang short well beyond the expected run length
	initial begin
		#(40000 * 8);
		fails++;
		tally_and_finish();
	end

endmodule : test_flash_clock_protect_irq
